// >>> rtl/uzs_params.svh
// Constants for the user zone select and read command handler
`ifndef UZS_PARAMS_SVH
`define UZS_PARAMS_SVH

// ==========================================================
// Command byte function codes (low nibble)
`define UZS_FN_SELECT 4'h1
`define UZS_FN_READ 4'h2

// ==========================================================
// Reply framing bytes
`define UZS_ACK 8'h00
`define UZS_NACK 8'h01

// ==========================================================
// Status codes
`define UZS_ST_OK 8'h00
`define UZS_ST_NO_ZONE 8'h99
`define UZS_ST_COMMAND_PARAMETER 8'ha1
`define UZS_ST_ADDR 8'ha2
`define UZS_ST_LEN 8'ha3
`define UZS_ST_AUTH 8'ha9
`define UZS_ST_PASSWORD 8'hd9
`define UZS_ST_MEMORY 8'hee

// ==========================================================
// Parameter byte layout
`define UZS_READ_NORMAL 8'h00
`define UZS_TEAR_BIT 7
`define UZS_RSVD_HI 6
`define UZS_RSVD_LO 4
`define UZS_ZONE_HI 3
`define UZS_ZONE_LO 0

// ==========================================================
// Security modes on sec_mode_i
`define UZS_SEC_NORMAL 2'h0
`define UZS_SEC_AUTH 2'h1
`define UZS_SEC_ENCRYPT 2'h2

// ==========================================================
// Frame lengths without the CRC bytes, and the receive byte counter limit
`define UZS_SEL_FRAME_LEN 3'h2
`define UZS_READ_FRAME_LEN 3'h4
`define UZS_RX_CNT_MAX 3'h7

// ==========================================================
// Reply checksum and reset values
`define UZS_CRC_INIT 16'hffff
`define UZS_CRC_POLY 16'h8408
`define UZS_ZONE_RST 4'h0
`define UZS_TEAR_RST 1'b0

`endif

// >>> rtl/uzs_pkg.sv
// Types shared by the user zone select and read command handler
package uzs_pkg;

  typedef logic [7:0] uzs_byte_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ECHO,
    S_FETCH,
    S_ACK,
    S_DATA,
    S_STATUS,
    S_CRC1,
    S_CRC2
  } uzs_state_e;

endpackage

// >>> rtl/uzs_crc_b.sv
// One byte step of the reply checksum (reflected, polynomial 0x8408)
`timescale 1ns/1ns
`include "uzs_params.svh"

module uzs_crc_b (
  input wire logic [15:0] crc_i,
  input wire uzs_pkg::uzs_byte_t data_i,
  output logic [15:0] crc_o
);
  import uzs_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `UZS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  assign crc_o = crc_step(crc_i, data_i);

endmodule

// >>> rtl/uzs_read_check.sv
// Ordered validity checks of a zone read request
`timescale 1ns/1ns
`include "uzs_params.svh"

module uzs_read_check #(
  parameter int ZONE_BYTES = 128
) (
  input wire logic zone_set_i,
  input wire uzs_pkg::uzs_byte_t command_parameter_i,
  input wire uzs_pkg::uzs_byte_t addr_i,
  input wire uzs_pkg::uzs_byte_t len_i,
  input wire logic [1:0] sec_mode_i,
  input wire logic zone_auth_req_i,
  input wire logic zone_enc_req_i,
  input wire logic zone_pw_req_i,
  input wire logic pw_verified_i,
  output logic fail_o,
  output uzs_pkg::uzs_byte_t status_o
);
  import uzs_pkg::*;

  localparam logic [8:0] ZONE_SIZE = 9'(ZONE_BYTES);

  // Nine bits so that an overrun past 255 is seen, not wrapped
  logic [8:0] end_excl;
  logic bad_addr;
  logic bad_len;
  logic need_sec;
  logic need_pw;

  assign end_excl = {1'b0, addr_i} + {1'b0, len_i} + 9'h001;
  assign bad_addr = {1'b0, addr_i} >= ZONE_SIZE;
  assign bad_len = ({1'b0, len_i} >= ZONE_SIZE) || (end_excl > ZONE_SIZE);
  assign need_sec = (zone_auth_req_i && (sec_mode_i == `UZS_SEC_NORMAL))
                 || (zone_enc_req_i && (sec_mode_i != `UZS_SEC_ENCRYPT));
  assign need_pw = zone_pw_req_i && !pw_verified_i;

  // First failing check wins
  assign status_o = !zone_set_i ? `UZS_ST_NO_ZONE :
                    (command_parameter_i != `UZS_READ_NORMAL) ? `UZS_ST_COMMAND_PARAMETER :
                    bad_addr ? `UZS_ST_ADDR :
                    bad_len ? `UZS_ST_LEN :
                    need_sec ? `UZS_ST_AUTH :
                    need_pw ? `UZS_ST_PASSWORD :
                    `UZS_ST_OK;
  assign fail_o = status_o != `UZS_ST_OK;

endmodule

// >>> rtl/uzs_top.sv
// Active-state zone select and zone read command handler
// Summary of operation
// - Command byte: channel id in upper nibble, function 1 selects, 2 reads.
// - Commands with foreign channel id or unknown function are dropped silently.
// - One zone is selected at a time; each accepted selection replaces the last.
// - Tear-guard choice from selection holds for zone writes until next selection.
// - Select parameter: tear-guard flag bit 7, zeros bits 6..4, zone bits 3..0.
// - Tear-guard flag 0 means normal writes, 1 means tear-guarded writes.
// - Zone field is an unsigned number from 0 to 15.
// - Both commands are answered only in the Active state, else silence.
// - Frames with transmission errors get no reply at all.
// - Selection answers ACK with status 00, or NACK with A1 on bad parameter.
// - Reply: echoed command byte, ACK/NACK, data, status, two CRC bytes.
// - Read parameter 00 is normal read with address, length and CRC bytes.
// - Length byte is count minus one, not above zone size.
// - Byte address advances by one after each memory fetch.
// - Reads running past the zone end are refused, never wrapped.
// - Successful read places data in address order between ACK and status.
// - In encryption mode only data bytes are encrypted.
// - In normal and authentication modes nothing is encrypted.
// - Read answers NACK 99 without zone, NACK A1 on bad parameter.
// - Read answers NACK A2 on bad address, NACK A3 on bad length.
// - NACK A9 when auth or encryption missing, NACK D9 when password missing.
// - Memory fault during read reports status EE with ACK or NACK.
// - Only the first detected error is reported in status.
`timescale 1ns/1ns
`include "uzs_params.svh"

module uzs_top #(
  parameter int NUM_ZONES = 16,
  parameter int ZONE_BYTES = 128
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic active_state_i,
  input wire logic [3:0] card_channel_id_i,
  input wire logic reactivate_i,
  input wire logic rx_valid_i,
  input wire uzs_pkg::uzs_byte_t rx_data_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic [1:0] sec_mode_i,
  input wire logic zone_auth_req_i,
  input wire logic zone_enc_req_i,
  input wire logic zone_pw_req_i,
  input wire logic pw_verified_i,
  input wire logic mem_ack_i,
  input wire uzs_pkg::uzs_byte_t mem_data_i,
  input wire logic mem_err_i,
  input wire uzs_pkg::uzs_byte_t keystream_i,
  input wire logic tx_ready_i,
  output logic mem_req_o,
  output logic [3:0] mem_zone_o,
  output uzs_pkg::uzs_byte_t mem_addr_o,
  output logic ks_next_o,
  output logic tx_valid_o,
  output uzs_pkg::uzs_byte_t tx_data_o,
  output logic tx_last_o,
  output logic zone_set_o,
  output logic [3:0] sel_zone_o,
  output logic tear_guard_o,
  output logic busy_o
);
  import uzs_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (NUM_ZONES < 1 || NUM_ZONES > 16) begin : g_bad_zones
    $error("uzs_top: NUM_ZONES must be 1 to 16");
  end
  if (ZONE_BYTES < 1 || ZONE_BYTES > 256) begin : g_bad_size
    $error("uzs_top: ZONE_BYTES must be 1 to 256");
  end

  localparam logic [4:0] ZONE_COUNT = 5'(NUM_ZONES);

  // ==========================================================
  // State
  uzs_state_e state_q;
  logic [2:0] rx_cnt_q;
  uzs_byte_t cmd_q;
  uzs_byte_t prm_q;
  uzs_byte_t adr_q;
  uzs_byte_t len_q;
  uzs_byte_t echo_q;
  uzs_byte_t status_q;
  uzs_byte_t data_q;
  uzs_byte_t rd_addr_q;
  uzs_byte_t rem_q;
  logic fail_q;
  logic rd_q;
  logic first_q;
  logic [15:0] crc_q;
  logic mem_req_q;
  logic ks_next_q;
  logic tx_valid_q;
  uzs_byte_t tx_data_q;
  logic tx_last_q;
  logic zone_set_q;
  logic [3:0] zone_q;
  logic tear_q;
  logic busy_q;

  // ==========================================================
  // Request decode
  logic cid_match;
  logic [3:0] func;
  logic frame_ok;
  logic is_sel;
  logic is_read;
  logic start_sel;
  logic start_read;
  logic sel_bad;
  logic rd_fail;
  uzs_byte_t rd_status;

  assign cid_match = cmd_q[7:4] == card_channel_id_i;
  assign func = cmd_q[3:0];
  // Bad CRC, wrong channel or not Active: drop without reply
  assign frame_ok = rx_end_i && rx_crc_ok_i && active_state_i
                 && cid_match && (state_q == S_IDLE);
  assign is_sel = (func == `UZS_FN_SELECT) && (rx_cnt_q == `UZS_SEL_FRAME_LEN);
  // A read with a foreign parameter may carry any trailer; with a zone selected it still gets A1
  assign is_read = (func == `UZS_FN_READ)
                && ((rx_cnt_q == `UZS_READ_FRAME_LEN)
                 || ((rx_cnt_q >= `UZS_SEL_FRAME_LEN) && (prm_q != `UZS_READ_NORMAL)));
  assign start_sel = frame_ok && is_sel;
  assign start_read = frame_ok && is_read;
  assign sel_bad = (prm_q[`UZS_RSVD_HI:`UZS_RSVD_LO] != 3'h0)
                || ({1'b0, prm_q[`UZS_ZONE_HI:`UZS_ZONE_LO]} >= ZONE_COUNT);

  uzs_read_check #(
    .ZONE_BYTES(ZONE_BYTES)
  ) u_check (
    .zone_set_i(zone_set_q),
    .command_parameter_i(prm_q),
    .addr_i(adr_q),
    .len_i(len_q),
    .sec_mode_i(sec_mode_i),
    .zone_auth_req_i(zone_auth_req_i),
    .zone_enc_req_i(zone_enc_req_i),
    .zone_pw_req_i(zone_pw_req_i),
    .pw_verified_i(pw_verified_i),
    .fail_o(rd_fail),
    .status_o(rd_status)
  );

  // ==========================================================
  // Reply byte selection and checksum
  logic enc_on;
  logic tx_free;
  logic sending;
  logic crc_byte;
  uzs_byte_t tx_byte;
  logic [15:0] crc_nxt;

  assign enc_on = sec_mode_i == `UZS_SEC_ENCRYPT;
  assign tx_free = !tx_valid_q || tx_ready_i;
  assign sending = tx_free && (state_q != S_IDLE) && (state_q != S_FETCH);
  assign crc_byte = (state_q == S_CRC1) || (state_q == S_CRC2);

  always_comb begin
    case (state_q)
      S_ECHO: tx_byte = echo_q;
      S_ACK: tx_byte = fail_q ? `UZS_NACK : `UZS_ACK;
      S_DATA: tx_byte = enc_on ? (data_q ^ keystream_i) : data_q;
      S_STATUS: tx_byte = status_q;
      S_CRC1: tx_byte = ~crc_q[7:0];
      S_CRC2: tx_byte = ~crc_q[15:8];
      default: tx_byte = 8'h00;
    endcase
  end

  uzs_crc_b u_crc (
    .crc_i(crc_q),
    .data_i(tx_byte),
    .crc_o(crc_nxt)
  );

  // ==========================================================
  // Receive capture
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_cnt_q <= 3'h0;
      cmd_q <= 8'h00;
      prm_q <= 8'h00;
      adr_q <= 8'h00;
      len_q <= 8'h00;
    end else if (clk_en_i) begin
      if (rx_end_i) begin
        rx_cnt_q <= 3'h0;
      end else if (rx_valid_i && (state_q == S_IDLE)) begin
        case (rx_cnt_q)
          3'h0: cmd_q <= rx_data_i;
          3'h1: prm_q <= rx_data_i;
          3'h2: adr_q <= rx_data_i;
          3'h3: len_q <= rx_data_i;
          default: ;
        endcase
        // Saturate so an overlong frame never aliases a legal length
        if (rx_cnt_q != `UZS_RX_CNT_MAX) begin
          rx_cnt_q <= rx_cnt_q + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // Zone selection
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zone_set_q <= 1'b0;
      zone_q <= `UZS_ZONE_RST;
      tear_q <= `UZS_TEAR_RST;
    end else if (clk_en_i) begin
      if (reactivate_i) begin
        zone_set_q <= 1'b0;
      end
      // Accepted selection wins over a simultaneous reactivation
      if (start_sel && !sel_bad) begin
        zone_set_q <= 1'b1;
        zone_q <= prm_q[`UZS_ZONE_HI:`UZS_ZONE_LO];
        tear_q <= prm_q[`UZS_TEAR_BIT];
      end
    end
  end

  // ==========================================================
  // Reply sequencer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= S_IDLE;
      echo_q <= 8'h00;
      status_q <= 8'h00;
      data_q <= 8'h00;
      rd_addr_q <= 8'h00;
      rem_q <= 8'h00;
      fail_q <= 1'b0;
      rd_q <= 1'b0;
      first_q <= 1'b0;
      crc_q <= `UZS_CRC_INIT;
      mem_req_q <= 1'b0;
      ks_next_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (clk_en_i) begin
      ks_next_q <= 1'b0;
      if (tx_valid_q && tx_ready_i) begin
        tx_valid_q <= 1'b0;
        tx_last_q <= 1'b0;
      end
      if (sending) begin
        tx_valid_q <= 1'b1;
        tx_data_q <= tx_byte;
        tx_last_q <= state_q == S_CRC2;
        if (!crc_byte) begin
          crc_q <= crc_nxt;
        end
      end
      case (state_q)
        S_IDLE: begin
          crc_q <= `UZS_CRC_INIT;
          echo_q <= cmd_q;
          first_q <= 1'b1;
          rd_addr_q <= adr_q;
          rem_q <= len_q;
          if (start_sel) begin
            rd_q <= 1'b0;
            fail_q <= sel_bad;
            status_q <= sel_bad ? `UZS_ST_COMMAND_PARAMETER : `UZS_ST_OK;
            busy_q <= 1'b1;
            state_q <= S_ECHO;
          end else if (start_read) begin
            rd_q <= 1'b1;
            fail_q <= rd_fail;
            status_q <= rd_status;
            busy_q <= 1'b1;
            state_q <= S_ECHO;
          end
        end
        S_ECHO: begin
          if (tx_free) begin
            // First data byte is fetched before ACK so a fault can still NACK
            state_q <= (rd_q && !fail_q) ? S_FETCH : S_ACK;
          end
        end
        S_FETCH: begin
          if (!mem_req_q) begin
            mem_req_q <= 1'b1;
          end else if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            data_q <= mem_data_i;
            rd_addr_q <= rd_addr_q + 8'h01;
            first_q <= 1'b0;
            if (mem_err_i) begin
              status_q <= `UZS_ST_MEMORY;
              fail_q <= first_q;
              state_q <= first_q ? S_ACK : S_STATUS;
            end else begin
              state_q <= first_q ? S_ACK : S_DATA;
            end
          end
        end
        S_ACK: begin
          if (tx_free) begin
            state_q <= (rd_q && !fail_q) ? S_DATA : S_STATUS;
          end
        end
        S_DATA: begin
          if (tx_free) begin
            ks_next_q <= enc_on;
            if (rem_q == 8'h00) begin
              state_q <= S_STATUS;
            end else begin
              rem_q <= rem_q - 8'h01;
              state_q <= S_FETCH;
            end
          end
        end
        S_STATUS: begin
          if (tx_free) begin
            state_q <= S_CRC1;
          end
        end
        S_CRC1: begin
          if (tx_free) begin
            state_q <= S_CRC2;
          end
        end
        S_CRC2: begin
          if (tx_free) begin
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign mem_req_o = mem_req_q;
  assign mem_zone_o = zone_q;
  assign mem_addr_o = rd_addr_q;
  assign ks_next_o = ks_next_q;
  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign tx_last_o = tx_last_q;
  assign zone_set_o = zone_set_q;
  assign sel_zone_o = zone_q;
  assign tear_guard_o = tear_q;
  assign busy_o = busy_q;

endmodule

// >>> bench/uzs_asserts.sv
// Concurrent checks on the zone select and read handler ports
`timescale 1ns/1ns
`include "uzs_params.svh"

module uzs_asserts (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic active_state_i,
  input wire logic reactivate_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic [1:0] sec_mode_i,
  input wire logic mem_ack_i,
  input wire logic tx_ready_i,
  input wire logic mem_req_o,
  input wire uzs_pkg::uzs_byte_t mem_addr_o,
  input wire logic ks_next_o,
  input wire logic tx_valid_o,
  input wire uzs_pkg::uzs_byte_t tx_data_o,
  input wire logic tx_last_o,
  input wire logic zone_set_o,
  input wire logic busy_o
);
  import uzs_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Memory side
  a_fetch_hold: assert property (clk_en_i && mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch request dropped early");
  a_addr_step: assert property (clk_en_i && mem_req_o && mem_ack_i |=> mem_addr_o == $past(mem_addr_o) + 8'h01)
    else $error("fetch address did not advance by one");
  // ==========================================================
  // Reply side
  a_tx_stands: assert property (clk_en_i && tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed before acceptance");
  a_last_closes: assert property (clk_en_i && tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o && !busy_o)
    else $error("reply continued after last byte");
  a_crc_quiet: assert property (rx_end_i && !rx_crc_ok_i && !busy_o |=> (!busy_o && !tx_valid_o) [*2])
    else $error("reply to a damaged frame");
  a_start_cause: assert property ($rose(busy_o) |-> $past(rx_end_i && rx_crc_ok_i && active_state_i))
    else $error("command started without a good frame end");
  // ==========================================================
  // Selection and cipher
  a_react_clear: assert property (clk_en_i && reactivate_i && !rx_end_i |=> !zone_set_o)
    else $error("selection kept after reactivation");
  a_ks_mode: assert property (ks_next_o |-> $past(sec_mode_i) == `UZS_SEC_ENCRYPT)
    else $error("keystream used outside encryption mode");
endmodule

bind uzs_top uzs_asserts u_uzs_asserts (.clock_i, .rst_b_i, .clk_en_i, .active_state_i, .reactivate_i, .rx_end_i,
  .rx_crc_ok_i, .sec_mode_i, .mem_ack_i, .tx_ready_i, .mem_req_o, .mem_addr_o, .ks_next_o, .tx_valid_o,
  .tx_data_o, .tx_last_o, .zone_set_o, .busy_o);

// >>> bench/uzs_mem_model.sv
// Behavioural user memory answering fetch requests
`timescale 1ns/1ns

module uzs_mem_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic [3:0] zone_i,
  input wire uzs_pkg::uzs_byte_t addr_i,
  input wire logic [3:0] lat_i,
  input wire uzs_pkg::uzs_byte_t err_addr_i,
  output logic ack_o,
  output uzs_pkg::uzs_byte_t rdata_o,
  output logic err_o
);
  import uzs_pkg::*;
  logic [3:0] wait_q;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_q <= 4'h0;
      ack_o <= 1'b0;
      rdata_o <= 8'h00;
      err_o <= 1'b0;
    end else if (req_i && !ack_o && wait_q >= lat_i) begin
      wait_q <= 4'h0;
      ack_o <= 1'b1;
      rdata_o <= {zone_i, 4'h0} ^ addr_i ^ 8'h5a;
      err_o <= (addr_i == err_addr_i);
    end else begin
      // Outside an answer data and error invert every cycle, so the stale byte shows every other cycle
      wait_q <= (req_i && !ack_o) ? wait_q + 4'h1 : 4'h0;
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      err_o <= ~err_o;
    end
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking testbench for the zone select and read handler
`timescale 1ns/1ns
`include "uzs_params.svh"

module tb_top;
  import uzs_pkg::*;
  logic clock_i = 1'b0, rst_b_i = 1'b0, clk_en_i = 1'b1, active_state_i = 1'b1, reactivate_i = 1'b0;
  logic rx_valid_i = 1'b0, rx_end_i = 1'b0, rx_crc_ok_i = 1'b0, tx_ready_i = 1'b1, stall = 1'b0;
  logic zone_auth_req_i = 1'b0, zone_enc_req_i = 1'b0, zone_pw_req_i = 1'b0, pw_verified_i = 1'b0;
  logic [3:0] card_channel_id_i = 4'h5, lat = 4'h0, zone_m = 4'h0;
  logic [1:0] sec_mode_i = `UZS_SEC_NORMAL;
  uzs_byte_t rx_data_i = 8'h00, keystream_i = 8'h3c, err_addr = 8'hff, ks_m = 8'h00;
  logic mem_ack_i, mem_err_i, mem_req_o, ks_next_o, tx_valid_o, tx_last_o, zone_set_o, tear_guard_o, busy_o;
  logic [3:0] mem_zone_o, sel_zone_o;
  uzs_byte_t mem_data_i, mem_addr_o, tx_data_o;
  uzs_byte_t fr[4];
  uzs_byte_t exp_q[$], got_q[$];
  int errors = 0, cmp_count = 0;

  always #50 clock_i = ~clock_i;
  // Stalling holds tx_ready_i low on every other cycle
  always @(negedge clock_i) tx_ready_i <= stall ? ~tx_ready_i : 1'b1;

  uzs_top u_uzs_top (.clock_i, .rst_b_i, .clk_en_i, .active_state_i, .card_channel_id_i, .reactivate_i,
    .rx_valid_i, .rx_data_i, .rx_end_i, .rx_crc_ok_i, .sec_mode_i, .zone_auth_req_i, .zone_enc_req_i,
    .zone_pw_req_i, .pw_verified_i, .mem_ack_i, .mem_data_i, .mem_err_i, .keystream_i, .tx_ready_i,
    .mem_req_o, .mem_zone_o, .mem_addr_o, .ks_next_o, .tx_valid_o, .tx_data_o, .tx_last_o, .zone_set_o,
    .sel_zone_o, .tear_guard_o, .busy_o);
  uzs_mem_model u_uzs_mem_model (.clock_i, .rst_b_i, .req_i(mem_req_o), .zone_i(mem_zone_o),
    .addr_i(mem_addr_o), .lat_i(lat), .err_addr_i(err_addr), .ack_o(mem_ack_i), .rdata_o(mem_data_i),
    .err_o(mem_err_i));

  // ==========================================================
  // Reporting
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_byte(string what, uzs_byte_t exp, uzs_byte_t got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask

  // ==========================================================
  // Frame driving and reply checking
  function automatic logic [15:0] crc_b(uzs_byte_t q[$]);
    logic [15:0] c = `UZS_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `UZS_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic send(int n, logic ok);
    for (int i = 0; i < n; i++) begin
      @(negedge clock_i);
      rx_valid_i = 1'b1;
      rx_data_i = fr[i];
    end
    @(negedge clock_i);
    rx_valid_i = 1'b0;
    rx_end_i = 1'b1;
    rx_crc_ok_i = ok;
    @(negedge clock_i);
    rx_end_i = 1'b0;
  endtask
  task automatic reply(uzs_byte_t ack, int nd, uzs_byte_t a0, uzs_byte_t st);
    int k = 0;
    logic fin = 1'b0;
    logic [15:0] c;
    exp_q = {fr[0], ack};
    for (int i = 0; i < nd; i++) exp_q.push_back({zone_m, 4'h0} ^ (a0 + 8'(i)) ^ 8'h5a ^ ks_m);
    exp_q.push_back(st);
    c = crc_b(exp_q);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
    got_q = {};
    while (!fin && k < 500) begin
      @(posedge clock_i);
      k++;
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
        got_q.push_back(tx_data_o);
        fin = (tx_last_o === 1'b1);
      end
    end
    if (!fin) begin
      errors++;
      $display("CHECK FAILED reply end expected 1 seen 0");
      final_report();
    end
    chk_byte("reply length", 8'(exp_q.size()), 8'(got_q.size()));
    foreach (exp_q[i]) chk_byte("reply byte", exp_q[i], i < got_q.size() ? got_q[i] : 8'hxx);
    // Hand back off the sampling edge so callers may change inputs at once
    @(negedge clock_i);
  endtask
  task automatic sel(uzs_byte_t p, uzs_byte_t ack, uzs_byte_t st);
    fr[0] = {card_channel_id_i, `UZS_FN_SELECT};
    fr[1] = p;
    send(2, 1'b1);
    reply(ack, 0, 8'h00, st);
  endtask
  task automatic rd(uzs_byte_t p, uzs_byte_t a, uzs_byte_t l, uzs_byte_t ack, int nd, uzs_byte_t st);
    fr = '{{card_channel_id_i, `UZS_FN_READ}, p, a, l};
    send(4, 1'b1);
    reply(ack, nd, a, st);
  endtask
  task automatic quiet(int n, logic ok);
    send(n, ok);
    repeat (6) begin
      @(negedge clock_i);
      chk_bit("silence", 1'b0, busy_o | tx_valid_o);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk_bit("zone set", 1'b0, zone_set_o);
    rd(8'h00, 8'h00, 8'h00, `UZS_NACK, 0, `UZS_ST_NO_ZONE);
    $display("test reset finished");
  endtask
  task automatic t_select();
    logic [3:0] zl[3] = '{4'h0, 4'h9, 4'hf};
    logic tl[3] = '{1'b1, 1'b0, 1'b1};
    foreach (zl[i]) begin
      zone_m = zl[i];
      sel({tl[i], 3'h0, zl[i]}, `UZS_ACK, `UZS_ST_OK);
      chk_bit("tear guard", tl[i], tear_guard_o);
      chk_byte("zone", {4'h0, zl[i]}, {4'h0, sel_zone_o});
    end
    sel(8'h93, `UZS_NACK, `UZS_ST_COMMAND_PARAMETER);
    chk_byte("zone kept", 8'h0f, {4'h0, sel_zone_o});
    chk_bit("tear kept", 1'b1, tear_guard_o);
    $display("test select finished");
  endtask
  task automatic t_ignore();
    fr[0] = {4'h6, `UZS_FN_SELECT};
    fr[1] = 8'h02;
    quiet(2, 1'b1);
    fr[0] = {card_channel_id_i, 4'h3};
    quiet(2, 1'b1);
    fr[0] = {card_channel_id_i, `UZS_FN_SELECT};
    quiet(3, 1'b1);
    quiet(2, 1'b0);
    active_state_i = 1'b0;
    quiet(2, 1'b1);
    active_state_i = 1'b1;
    chk_byte("zone kept", 8'h0f, {4'h0, sel_zone_o});
    $display("test ignore finished");
  endtask
  task automatic t_read();
    zone_m = 4'h3;
    sel(8'h03, `UZS_ACK, `UZS_ST_OK);
    stall = 1'b1;
    lat = 4'h3;
    rd(8'h00, 8'h0a, 8'h03, `UZS_ACK, 4, `UZS_ST_OK);
    rd(8'h00, 8'h7c, 8'h03, `UZS_ACK, 4, `UZS_ST_OK);
    stall = 1'b0;
    lat = 4'h0;
    $display("test read finished");
  endtask
  task automatic t_errors();
    fr[0] = {card_channel_id_i, `UZS_FN_READ};
    fr[1] = 8'h01;
    send(2, 1'b1);
    reply(`UZS_NACK, 0, 8'h00, `UZS_ST_COMMAND_PARAMETER);
    rd(8'h01, 8'hc8, 8'h00, `UZS_NACK, 0, `UZS_ST_COMMAND_PARAMETER);
    rd(8'h00, 8'h80, 8'h00, `UZS_NACK, 0, `UZS_ST_ADDR);
    rd(8'h00, 8'h7d, 8'h03, `UZS_NACK, 0, `UZS_ST_LEN);
    zone_auth_req_i = 1'b1;
    rd(8'h00, 8'h00, 8'h00, `UZS_NACK, 0, `UZS_ST_AUTH);
    zone_auth_req_i = 1'b0;
    zone_pw_req_i = 1'b1;
    rd(8'h00, 8'h00, 8'h00, `UZS_NACK, 0, `UZS_ST_PASSWORD);
    pw_verified_i = 1'b1;
    rd(8'h00, 8'h00, 8'h00, `UZS_ACK, 1, `UZS_ST_OK);
    zone_pw_req_i = 1'b0;
    pw_verified_i = 1'b0;
    $display("test errors finished");
  endtask
  task automatic t_crypt();
    sec_mode_i = `UZS_SEC_AUTH;
    zone_enc_req_i = 1'b1;
    rd(8'h00, 8'h10, 8'h01, `UZS_NACK, 0, `UZS_ST_AUTH);
    sec_mode_i = `UZS_SEC_ENCRYPT;
    ks_m = keystream_i;
    rd(8'h00, 8'h10, 8'h01, `UZS_ACK, 2, `UZS_ST_OK);
    zone_enc_req_i = 1'b0;
    sec_mode_i = `UZS_SEC_AUTH;
    ks_m = 8'h00;
    rd(8'h00, 8'h10, 8'h01, `UZS_ACK, 2, `UZS_ST_OK);
    sec_mode_i = `UZS_SEC_NORMAL;
    $display("test crypt finished");
  endtask
  task automatic t_memerr();
    err_addr = 8'h14;
    rd(8'h00, 8'h14, 8'h01, `UZS_NACK, 0, `UZS_ST_MEMORY);
    err_addr = 8'h15;
    rd(8'h00, 8'h14, 8'h01, `UZS_ACK, 1, `UZS_ST_MEMORY);
    err_addr = 8'hff;
    $display("test memerr finished");
  endtask
  task automatic t_react();
    @(negedge clock_i);
    clk_en_i = 1'b0;
    reactivate_i = 1'b1;
    @(negedge clock_i);
    chk_bit("frozen zone set", 1'b1, zone_set_o);
    clk_en_i = 1'b1;
    @(negedge clock_i);
    reactivate_i = 1'b0;
    chk_bit("zone set", 1'b0, zone_set_o);
    rd(8'h00, 8'h00, 8'h00, `UZS_NACK, 0, `UZS_ST_NO_ZONE);
    // Reset in mid-run must also drop the remembered zone number
    rst_b_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    chk_byte("zone after reset", 8'h00, {4'h0, sel_zone_o});
    $display("test react finished");
  endtask

  initial begin
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_reset();
    t_select();
    t_ignore();
    t_read();
    t_errors();
    t_crypt();
    t_memerr();
    t_react();
    final_report();
  end
endmodule
